// ==== logic/flash_link_pkg.sv ====
// shared constants and types for the flash driver serial link, both ends
// ==========================================================================
package flash_link_pkg;
  localparam logic [6:0] TARGET_ADDR = 7'h64;
  // ==========================================================================
  // register map of the device
  localparam logic [7:0] ENABLE_CONTROL = 8'h01;
  localparam logic [7:0] CONFIGURATION = 8'h02;
  localparam logic [7:0] PULSE_BRIGHTNESS = 8'h03;
  localparam logic [7:0] STEADY_BRIGHTNESS = 8'h04;
  localparam logic [7:0] FAULT_FLAGS = 8'h05;
  localparam logic [7:0] IDENTITY_AND_SOFT_RESET = 8'h06;
  localparam logic [7:0] ENABLE_RESET = 8'h20;
  localparam logic [7:0] CONFIG_RESET = 8'h15;
  localparam logic [7:0] PULSE_RESET = 8'h80;
  localparam logic [7:0] STEADY_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  // identity fields: values arbitrary
  localparam logic [2:0] DEVICE_ID_CODE = 3'h2;
  localparam logic [1:0] REVISION_CODE = 2'h2;
  localparam int SOFT_RESET_BIT = 7;
  localparam int SYNC_ENABLE_BIT = 6;
  localparam int SYNC_FLAG_BIT = 2;
  // fault flag bit positions
  localparam int OVERVOLT_FAULT_FLAG = 7;
  localparam int DROOP_TRIP_FLAG = 6;
  localparam int SHORT_FAULT_FLAG = 5;
  localparam int CURRENT_LIMIT_FLAG = 4;
  localparam int THERMAL_REDUCE_FLAG = 3;
  localparam int OVERHEAT_FAULT_FLAG = 2;
  localparam int LOW_INPUT_FAULT_FLAG = 1;
  localparam int PULSE_TIMEOUT_FLAG = 0;
  // ==========================================================================
  // host register map on apb
  localparam logic [7:0] HOST_COMMAND = 8'h00;
  localparam logic [7:0] HOST_TX_DATA = 8'h04;
  localparam logic [7:0] HOST_RX_DATA = 8'h08;
  localparam logic [7:0] HOST_STATUS = 8'h0c;
  localparam logic [7:0] HOST_IRQ_STATUS = 8'h10;
  localparam logic [7:0] HOST_IRQ_MASK = 8'h14;
  localparam int CMD_GO = 0;
  localparam int CMD_START = 1;
  localparam int CMD_STOP = 2;
  localparam int CMD_READ = 3;
  localparam int CMD_ACK = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_NACK = 1;
  // ==========================================================================
  // timing
  localparam int PCLK_PERIOD_NS = 5;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QUARTER_CYCLES = SCL_PERIOD_NS / (4 * PCLK_PERIOD_NS);
  localparam logic [7:0] QUARTER_LOAD = 8'(QUARTER_CYCLES - 1);
  // ==========================================================================
  typedef enum logic [2:0] {
    st_idle = 3'b000, st_rx = 3'b001, st_rx_ack = 3'b011,
    st_tx = 3'b010, st_tx_ack = 3'b110, st_wait = 3'b111
  } dev_state_type;
  typedef enum logic [1:0] {
    KIND_ADDR = 2'h0, KIND_PTR = 2'h1, KIND_DATA = 2'h2
  } byte_kind_type;
  typedef enum logic [1:0] {
    h_idle = 2'b00, h_start = 2'b01, h_bits = 2'b11, h_stop = 2'b10
  } host_state_type;
endpackage : flash_link_pkg

// ==== logic/flash_link_if.sv ====
// two-wire link between bus host and flash driver device
`timescale 1ns/1ps
interface flash_link_if;
  logic scl_host_out;
  logic scl_host_oe;
  logic sda_host_out;
  logic sda_host_oe;
  logic sda_dev_out;
  logic sda_dev_oe;
  logic scl_in;
  logic sda_in;
  // open-drain wires with pull-ups
  assign scl_in = ~(scl_host_oe & ~scl_host_out);
  assign sda_in = ~(sda_host_oe & ~sda_host_out) & ~(sda_dev_oe & ~sda_dev_out);
  modport host (output scl_host_out, scl_host_oe, sda_host_out, sda_host_oe,
                input scl_in, sda_in);
  modport device (output sda_dev_out, sda_dev_oe, input scl_in, sda_in);
endinterface : flash_link_if

// ==== logic/flash_led_target.sv ====
// serial target and register bank of the flash led driver
`timescale 1ns/1ps
module flash_led_target
  import flash_link_pkg::*;
(
  input wire logic pclk, // system clock
  input wire logic presetn, // power-on reset, active low
  flash_link_if.device link, // two-wire link
  input wire logic [7:0] fault_events, // fault pulses, flag layout
  input wire logic sync_event, // transmit-sync pulse
  output logic pass_mode_on, // pass mode instead of boost
  output logic switch_rate_select, // 1 selects faster switching
  output logic inductor_limit_select, // 1 selects higher limit
  output logic input_droop_monitor_on, // droop monitor enable
  output logic trigger_edge_mode, // trigger pin edge sensitive
  output logic trigger_pin_on, // trigger pin enable
  output logic [1:0] drive_mode, // standby, infrared, steady, pulse
  output logic [2:0] input_droop_threshold, // droop threshold code
  output logic [3:0] pulse_time_code, // pulse time-limit code
  output logic steady_ramp_on, // steady light ramp
  output logic thermal_current_reduce_on, // thermal scale-back enable
  output logic [6:0] pulse_current_level, // pulse current code
  output logic [7:0] steady_current_level, // steady current code
  output logic sync_enable, // transmit-sync enable
  output logic fault_read // pulse: fault flags read, blocked operation may resume
);
  // ==========================================================================
  // register bank
  logic [7:0] enable_control;
  logic [7:0] configuration;
  logic [7:0] pulse_brightness;
  logic [7:0] steady_brightness;
  logic [7:0] fault_flags;
  logic sync_flag;

  function automatic logic [7:0] reg_read(input logic [7:0] addr);
    if (addr == ENABLE_CONTROL) begin
      reg_read = enable_control;
    end else if (addr == CONFIGURATION) begin
      reg_read = configuration;
    end else if (addr == PULSE_BRIGHTNESS) begin
      reg_read = pulse_brightness;
    end else if (addr == STEADY_BRIGHTNESS) begin
      reg_read = steady_brightness;
    end else if (addr == FAULT_FLAGS) begin
      reg_read = fault_flags;
    end else if (addr == IDENTITY_AND_SOFT_RESET) begin
      reg_read = {1'b0, sync_enable, DEVICE_ID_CODE, sync_flag, REVISION_CODE};
    end else begin
      reg_read = 8'h00;
    end
  endfunction : reg_read

  // ==========================================================================
  // pin sampling: three stages, a change counts once stages two and three agree
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic scl_f;
  logic sda_f;
  logic scl_p;
  logic sda_p;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], link.scl_in};
      sda_sync <= {sda_sync[1:0], link.sda_in};
      if (scl_sync[2] == scl_sync[1]) begin
        scl_f <= scl_sync[1];
      end
      if (sda_sync[2] == sda_sync[1]) begin
        sda_f <= sda_sync[1];
      end
      scl_p <= scl_f;
      sda_p <= sda_f;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  assign scl_rise = scl_f & ~scl_p;
  assign scl_fall = ~scl_f & scl_p;
  // data moving while clock stays high is a start or a stop
  assign start_cond = scl_f & scl_p & sda_p & ~sda_f;
  assign stop_cond = scl_f & scl_p & ~sda_p & sda_f;

  // ==========================================================================
  // byte engine
  dev_state_type state;
  byte_kind_type kind;
  logic [3:0] cnt;
  logic [7:0] shifter;
  logic [7:0] ptr;
  logic reading;
  logic host_ack;

  logic byte_done;
  logic ack_end;
  logic read_next;
  logic load_tx;
  logic [7:0] load_addr;
  logic write_pulse;
  assign byte_done = (state == st_rx) && scl_fall && (cnt == 4'h8);
  assign ack_end = (state == st_rx_ack) && scl_fall;
  assign read_next = (state == st_tx_ack) && scl_fall && host_ack;
  assign load_tx = (ack_end && kind == KIND_ADDR && reading) || read_next;
  assign load_addr = read_next ? ptr + 8'h01 : ptr;
  assign write_pulse = byte_done && kind == KIND_DATA;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_idle;
      kind <= KIND_ADDR;
      cnt <= 4'h0;
      shifter <= 8'h00;
      reading <= 1'b0;
      host_ack <= 1'b0;
    end else if (start_cond) begin
      state <= st_rx;
      kind <= KIND_ADDR;
      cnt <= 4'h0;
    end else if (stop_cond) begin
      state <= st_idle;
    end else begin
      case (state)
        st_rx: begin
          if (scl_rise) begin
            shifter <= {shifter[6:0], sda_f};
            cnt <= cnt + 4'h1;
          end else if (byte_done) begin
            cnt <= 4'h0;
            if (kind != KIND_ADDR) begin
              state <= st_rx_ack;
            end else if (shifter[7:1] == TARGET_ADDR) begin
              reading <= shifter[0];
              state <= st_rx_ack;
            end else begin
              state <= st_wait;
            end
          end
        end
        st_rx_ack: begin
          if (load_tx) begin
            shifter <= reg_read(load_addr);
            state <= st_tx;
          end else if (ack_end) begin
            state <= st_rx;
            kind <= (kind == KIND_ADDR) ? KIND_PTR : KIND_DATA;
          end
        end
        st_tx: begin
          if (scl_fall) begin
            if (cnt == 4'h7) begin
              cnt <= 4'h0;
              state <= st_tx_ack;
            end else begin
              shifter <= {shifter[6:0], 1'b0};
              cnt <= cnt + 4'h1;
            end
          end
        end
        st_tx_ack: begin
          if (scl_rise) begin
            host_ack <= ~sda_f;
          end else if (read_next) begin
            shifter <= reg_read(load_addr);
            state <= st_tx;
          end else if (scl_fall) begin
            state <= st_wait;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // register pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr <= 8'h00;
    end else if (byte_done && kind == KIND_PTR) begin
      ptr <= shifter;
    end else if (ack_end && kind == KIND_DATA) begin
      ptr <= ptr + 8'h01;
    end else if (read_next) begin
      ptr <= ptr + 8'h01;
    end
  end

  // data line: ack in rx_ack, zero bits in tx; released otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.sda_dev_oe <= 1'b0;
    end else begin
      link.sda_dev_oe <= (state == st_rx_ack) || (state == st_tx && !shifter[7]);
    end
  end
  assign link.sda_dev_out = 1'b0;

  // ==========================================================================
  // writable registers; soft reset restores them all
  logic soft_reset;
  assign soft_reset = write_pulse && ptr == IDENTITY_AND_SOFT_RESET
    && shifter[SOFT_RESET_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_control <= ENABLE_RESET;
      configuration <= CONFIG_RESET;
      pulse_brightness <= PULSE_RESET;
      steady_brightness <= STEADY_RESET;
      sync_enable <= 1'b0;
    end else if (soft_reset) begin
      enable_control <= ENABLE_RESET;
      configuration <= CONFIG_RESET;
      pulse_brightness <= PULSE_RESET;
      steady_brightness <= STEADY_RESET;
      sync_enable <= 1'b0;
    end else if (write_pulse) begin
      // fault flags, identity and revision ignore writes
      if (ptr == ENABLE_CONTROL) begin
        enable_control <= shifter;
      end else if (ptr == CONFIGURATION) begin
        configuration <= shifter;
      end else if (ptr == PULSE_BRIGHTNESS) begin
        pulse_brightness <= shifter;
      end else if (ptr == STEADY_BRIGHTNESS) begin
        steady_brightness <= shifter;
      end else if (ptr == IDENTITY_AND_SOFT_RESET) begin
        sync_enable <= shifter[SYNC_ENABLE_BIT];
      end
    end
  end

  // sticky flags: a new event wins over the read that clears
  logic flags_read;
  logic id_read;
  assign flags_read = load_tx && load_addr == FAULT_FLAGS;
  assign id_read = load_tx && load_addr == IDENTITY_AND_SOFT_RESET;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_flags <= FLAGS_RESET;
      sync_flag <= 1'b0;
      fault_read <= 1'b0;
    end else begin
      fault_read <= flags_read;
      if (soft_reset) begin
        fault_flags <= FLAGS_RESET | fault_events;
        sync_flag <= sync_enable & sync_event;
      end else begin
        fault_flags <= (flags_read ? 8'h00 : fault_flags) | fault_events;
        sync_flag <= (sync_flag & ~id_read) | (sync_enable & sync_event);
      end
    end
  end

  // ==========================================================================
  // field outputs
  assign pass_mode_on = enable_control[7];
  assign switch_rate_select = enable_control[6];
  assign inductor_limit_select = enable_control[5];
  assign input_droop_monitor_on = enable_control[4];
  assign trigger_edge_mode = enable_control[3];
  assign trigger_pin_on = enable_control[2];
  assign drive_mode = enable_control[1:0];
  assign input_droop_threshold = configuration[7:5];
  assign pulse_time_code = configuration[4:1];
  assign steady_ramp_on = configuration[0];
  assign thermal_current_reduce_on = pulse_brightness[7];
  assign pulse_current_level = pulse_brightness[6:0];
  assign steady_current_level = steady_brightness;
endmodule : flash_led_target

// ==== logic/flash_bus_host.sv ====
// two-wire bus host controller with apb command registers
`timescale 1ns/1ps
module flash_bus_host
  import flash_link_pkg::*;
(
  input wire logic pclk, // system clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  output logic irq, // level interrupt
  flash_link_if.host link // two-wire link
);
  // ==========================================================================
  // apb slave, one wait state
  logic apb_access;
  logic apb_write;
  logic [4:0] cmd;
  logic [7:0] tx_data;
  logic [7:0] rx_data;
  logic busy;
  logic nack;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic mapped;
  logic [31:0] read_value;
  logic go;

  assign apb_access = psel & penable & ~pready;
  assign apb_write = psel & penable & pready & pwrite;
  assign go = apb_write && paddr == HOST_COMMAND && pwdata[CMD_GO] && !busy;

  always_comb begin
    mapped = 1'b1;
    read_value = 32'h0;
    if (paddr == HOST_COMMAND) begin
      read_value = {27'h0, cmd[4:1], 1'b0};
    end else if (paddr == HOST_TX_DATA) begin
      read_value = {24'h0, tx_data};
    end else if (paddr == HOST_RX_DATA) begin
      read_value = {24'h0, rx_data};
    end else if (paddr == HOST_STATUS) begin
      read_value = {30'h0, nack, busy};
    end else if (paddr == HOST_IRQ_STATUS) begin
      read_value = {30'h0, irq_status};
    end else if (paddr == HOST_IRQ_MASK) begin
      read_value = {30'h0, irq_mask};
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_access;
      prdata <= apb_access ? read_value : 32'h0;
      pslverr <= apb_access & ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd <= 5'h0;
      tx_data <= 8'h00;
      irq_mask <= 2'h0;
    end else if (apb_write) begin
      if (paddr == HOST_COMMAND && !busy) begin
        cmd <= pwdata[4:0];
      end else if (paddr == HOST_TX_DATA) begin
        tx_data <= pwdata[7:0];
      end else if (paddr == HOST_IRQ_MASK) begin
        irq_mask <= pwdata[1:0];
      end
    end
  end

  // ==========================================================================
  // sampled data line
  logic [2:0] sda_sync;
  logic sda_f;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_sync <= 3'h7;
      sda_f <= 1'b1;
    end else begin
      sda_sync <= {sda_sync[1:0], link.sda_in};
      if (sda_sync[2] == sda_sync[1]) begin
        sda_f <= sda_sync[1];
      end
    end
  end

  // quarter-period tick of the serial clock divider
  logic [7:0] qcnt;
  logic tick;
  assign tick = busy && qcnt == 8'h00;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qcnt <= QUARTER_LOAD;
    end else if (go || tick) begin
      qcnt <= QUARTER_LOAD;
    end else if (busy) begin
      qcnt <= qcnt - 8'h01;
    end
  end

  // ==========================================================================
  // bit engine: each quarter is one step; data moves with clock low except at start and stop
  host_state_type state;
  logic [1:0] phase;
  logic [3:0] bitn;
  logic [7:0] shifter;
  logic out_bit;
  logic done;
  assign out_bit = bitn[3] ? (cmd[CMD_READ] ? ~cmd[CMD_ACK] : 1'b1) : shifter[7];
  assign done = tick && phase == 2'h3
    && (state == h_stop || (state == h_bits && bitn[3] && !cmd[CMD_STOP]));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= h_idle;
      phase <= 2'h0;
      bitn <= 4'h0;
      shifter <= 8'h00;
      link.scl_host_oe <= 1'b0;
      link.sda_host_oe <= 1'b0;
    end else if (go) begin
      state <= pwdata[CMD_START] ? h_start : h_bits;
      phase <= 2'h0;
      bitn <= 4'h0;
      shifter <= pwdata[CMD_READ] ? 8'hff : tx_data;
    end else if (tick) begin
      phase <= phase + 2'h1;
      case (state)
        h_start: begin
          // repeated start releases data first, then clock
          case (phase)
            2'h0: link.sda_host_oe <= 1'b0;
            2'h1: link.scl_host_oe <= 1'b0;
            2'h2: link.sda_host_oe <= 1'b1;
            default: begin
              link.scl_host_oe <= 1'b1;
              state <= h_bits;
            end
          endcase
        end
        h_bits: begin
          case (phase)
            2'h0: link.sda_host_oe <= ~out_bit;
            2'h1: link.scl_host_oe <= 1'b0;
            2'h2: begin
            end
            default: begin
              link.scl_host_oe <= 1'b1;
              // hand the data line over as the clock falls: the device drives a few cycles later
              if (bitn[3] || bitn[2:0] == 3'h7) begin
                link.sda_host_oe <= 1'b0;
              end
              if (bitn[3]) begin
                state <= cmd[CMD_STOP] ? h_stop : h_idle;
              end else begin
                shifter <= {shifter[6:0], 1'b1};
                bitn <= bitn + 4'h1;
              end
            end
          endcase
        end
        h_stop: begin
          case (phase)
            2'h0: link.sda_host_oe <= 1'b1;
            2'h1: link.scl_host_oe <= 1'b0;
            2'h2: link.sda_host_oe <= 1'b0;
            default: state <= h_idle;
          endcase
        end
        default: begin
        end
      endcase
    end
  end
  assign link.scl_host_out = 1'b0;
  assign link.sda_host_out = 1'b0;

  // ==========================================================================
  // sampling with clock high, status and interrupts
  logic sample;
  assign sample = tick && state == h_bits && phase == 2'h2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data <= 8'h00;
      nack <= 1'b0;
      busy <= 1'b0;
    end else begin
      if (go) begin
        busy <= 1'b1;
        nack <= 1'b0;
      end else if (done) begin
        busy <= 1'b0;
      end
      if (sample && !bitn[3]) begin
        rx_data <= {rx_data[6:0], sda_f};
      end else if (sample && !cmd[CMD_READ]) begin
        nack <= sda_f;
      end
    end
  end

  // set wins over write-one-to-clear
  logic [1:0] irq_set;
  logic [1:0] irq_clear;
  assign irq_set = {done & nack, done};
  assign irq_clear = (apb_write && paddr == HOST_IRQ_STATUS) ? pwdata[1:0] : 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 2'h0;
      irq <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_set;
      irq <= |((irq_status & ~irq_clear | irq_set) & irq_mask);
    end
  end
endmodule : flash_bus_host

// ==== testbench/flash_link_chk.sv ====
// concurrent checks on the two-wire link between host and device
`timescale 1ns/1ps
module flash_link_chk (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic scl_host_out, // host clock level
  input wire logic scl_host_oe, // host pulls clock
  input wire logic sda_host_out, // host data level
  input wire logic sda_host_oe, // host pulls data
  input wire logic sda_dev_out, // device data level
  input wire logic sda_dev_oe, // device pulls data
  input wire logic scl_in, // clock wire
  input wire logic sda_in // data wire
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // a byte of zeros is the longest the device may hold the line low
  logic [12:0] oe_run;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) oe_run <= 13'h0;
    else oe_run <= sda_dev_oe ? oe_run + 13'h1 : 13'h0;
  end
  sequence start_seen;
    scl_in && $fell(sda_in);
  endsequence
  sequence stop_seen;
    scl_in && $rose(sda_in);
  endsequence
  AST_OPEN_DRAIN: assert property (!scl_host_out && !sda_host_out && !sda_dev_out)
    else $error("open-drain pin driven high");
  AST_ONE_DRIVER: assert property (sda_dev_oe |-> !sda_host_oe)
    else $error("both ends pull data");
  AST_DEV_CHANGES_LOW: assert property ($changed(sda_dev_oe) |-> !scl_in)
    else $error("device changed data with clock high");
  AST_DEV_AFTER_FALL: assert property ($rose(sda_dev_oe) |-> !$past(scl_in, 3))
    else $error("device drove data too soon after clock fall");
  AST_SCL_HIGH: assert property ($rose(scl_in) |-> scl_in [*8])
    else $error("clock high phase too short");
  AST_START_RELEASE: assert property (start_seen |=> !sda_dev_oe [*8])
    else $error("device drove data after start");
  AST_STOP_RELEASE: assert property (stop_seen |=> !sda_dev_oe [*8])
    else $error("device drove data after stop");
  AST_BYTE_BOUND: assert property (oe_run <= 13'hfaa)
    else $error("device held data beyond one byte");
endmodule : flash_link_chk

// ==== testbench/tb_top.sv ====
// self-checking regression of host and flash driver over the two-wire link
`timescale 1ns/1ps
module tb_top;
  import flash_link_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, sync_event, sync_en;
  logic fault_read, err;
  logic cleared = 1'b0;
  logic [7:0] paddr, fault_events, d1, d2, f;
  wire logic [7:0] en_f, cf_f, lf_f, lt_f;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] lfsr;
  int n_errors, n_tests;
  flash_link_if link ();
  flash_bus_host flash_bus_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .link(link.host));
  flash_led_target flash_led_target_i (.pclk(pclk), .presetn(presetn), .link(link.device),
    .fault_events(fault_events), .sync_event(sync_event), .pass_mode_on(en_f[7]),
    .switch_rate_select(en_f[6]), .inductor_limit_select(en_f[5]),
    .input_droop_monitor_on(en_f[4]), .trigger_edge_mode(en_f[3]), .trigger_pin_on(en_f[2]),
    .drive_mode(en_f[1:0]), .input_droop_threshold(cf_f[7:5]), .pulse_time_code(cf_f[4:1]),
    .steady_ramp_on(cf_f[0]), .thermal_current_reduce_on(lf_f[7]),
    .pulse_current_level(lf_f[6:0]), .steady_current_level(lt_f), .sync_enable(sync_en),
    .fault_read(fault_read));
  flash_link_chk flash_link_chk_i (.pclk(pclk), .presetn(presetn),
    .scl_host_out(link.scl_host_out), .scl_host_oe(link.scl_host_oe),
    .sda_host_out(link.sda_host_out), .sda_host_oe(link.sda_host_oe),
    .sda_dev_out(link.sda_dev_out), .sda_dev_oe(link.sda_dev_oe), .scl_in(link.scl_in),
    .sda_in(link.sda_in));
  // ==========
  // helpers
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction : rnd
  function automatic logic [7:0] ident_value(input logic sync_on, input logic flag);
    return {1'b0, sync_on, DEVICE_ID_CODE, flag, REVISION_CODE};
  endfunction : ident_value
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // one idle edge after release keeps a following setup out of the same time step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic xfer(input logic [4:0] cmd, input logic [7:0] tx, input logic nk);
    int k;
    apb(1'b1, HOST_TX_DATA, {24'h0, tx});
    apb(1'b1, HOST_COMMAND, {27'h0, cmd});
    k = 0;
    while (irq !== 1'b1 && k < 7000) begin
      @(posedge pclk);
      k++;
    end
    check(irq, 32'h1);
    apb(1'b0, HOST_STATUS, 32'h0);
    check(rd[1:0], {30'h0, nk, 1'b0});
    apb(1'b1, HOST_IRQ_STATUS, 32'h3);
  endtask : xfer
  always @(posedge pclk) if (fault_read === 1'b1) cleared <= 1'b1;
  // ==========
  // clock, watchdog and scenarios
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    #480000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    lfsr = 16'h004d;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, fault_events, sync_event} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({en_f, cf_f, lf_f, lt_f}, 32'h20158000);
    apb(1'b1, HOST_IRQ_MASK, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    check(err, 32'h1);
    $display("reset and register bus test done");
    d1 = rnd();
    d2 = rnd();
    xfer(5'h03, 8'hc8, 1'b0);
    xfer(5'h01, ENABLE_CONTROL, 1'b0);
    xfer(5'h01, d1, 1'b0);
    xfer(5'h05, d2, 1'b0);
    check(en_f, d1);
    check(cf_f, d2);
    xfer(5'h07, 8'hca, 1'b1);
    $display("write burst and foreign address test done");
    xfer(5'h03, 8'hc8, 1'b0);
    xfer(5'h01, IDENTITY_AND_SOFT_RESET, 1'b0);
    xfer(5'h05, 8'h40, 1'b0);
    check(sync_en, 32'h1);
    f = rnd() | 8'h01;
    fault_events <= f;
    sync_event <= 1'b1;
    @(posedge pclk);
    fault_events <= 8'h00;
    sync_event <= 1'b0;
    xfer(5'h03, 8'hc8, 1'b0);
    xfer(5'h01, FAULT_FLAGS, 1'b0);
    xfer(5'h03, 8'hc9, 1'b0);
    xfer(5'h19, 8'hff, 1'b0);
    apb(1'b0, HOST_RX_DATA, 32'h0);
    check(rd, {24'h0, f});
    check(cleared, 32'h1);
    xfer(5'h0d, 8'hff, 1'b0);
    apb(1'b0, HOST_RX_DATA, 32'h0);
    check(rd, {24'h0, ident_value(1'b1, 1'b1)});
    $display("read burst test done");
    xfer(5'h03, 8'hc8, 1'b0);
    xfer(5'h01, FAULT_FLAGS, 1'b0);
    xfer(5'h01, rnd(), 1'b0);
    xfer(5'h05, 8'h80, 1'b0);
    check({en_f, cf_f, lf_f, lt_f}, 32'h20158000);
    check(sync_en, 32'h0);
    $display("soft reset test done");
    tally_and_finish();
  end
endmodule : tb_top
